// ===== ucs_pkg.sv
package ucs_pkg;

    localparam logic [7:0] ADDR_MUTE_HI   = 8'h05;
    localparam logic [7:0] ADDR_MUTE_LO   = 8'h06;
    localparam logic [7:0] ADDR_IO_SLEW   = 8'h07;
    localparam logic [7:0] ADDR_CLK_SLEW  = 8'h08;
    localparam logic [7:0] ADDR_SYNC_CTRL = 8'h09;
    localparam logic [7:0] ADDR_CAPTURE0  = 8'h0A;
    localparam logic [7:0] ADDR_CAPTURE1  = 8'h0B;
    localparam logic [7:0] ADDR_CAPTURE2  = 8'h0C;
    localparam logic [7:0] ADDR_CAPTURE3  = 8'h0D;

    localparam logic [7:0]  RST_MUTE_HI   = 8'hA4;
    localparam logic [7:0]  RST_MUTE_LO   = 8'h74;
    localparam logic [7:0]  RST_IO_SLEW   = 8'h80;
    localparam logic [7:0]  RST_CLK_SLEW  = 8'hA0;
    localparam logic [7:0]  RST_SYNC_CTRL = 8'h76;
    localparam logic [31:0] RST_CAPTURE   = 32'h0000_0000;
    localparam logic [7:0]  RDATA_NONE    = 8'h00;

    localparam int IO_RISE_MSB  = 7;
    localparam int IO_RISE_LSB  = 5;
    localparam int IO_FALL_MSB  = 4;
    localparam int IO_FALL_LSB  = 3;
    localparam int CLK_SLEW_MSB = 7;
    localparam int CLK_SLEW_LSB = 4;

    localparam int CTRL_CARD_TYPE  = 7;
    localparam int CTRL_ACT_MANUAL = 6;
    localparam int CTRL_AUX1       = 5;
    localparam int CTRL_AUX2       = 4;
    localparam int CTRL_RST_LEVEL  = 3;
    localparam int CTRL_CLK_GATE   = 2;
    localparam int CTRL_EDGE       = 1;
    localparam int CTRL_START      = 0;

    localparam int STATIC_LOW_BIT  = 1;
    localparam int STATIC_HIGH_BIT = 0;

    localparam int          ANSWER_BITS = 32;
    localparam logic [5:0]  CNT_ZERO    = 6'h00;
    localparam logic [5:0]  CNT_ONE     = 6'h01;
    localparam logic [5:0]  CNT_LAST    = 6'h1F;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ANSWER = 2'b01,
        ST_RUN    = 2'b10
    } ucs_state_e;

    typedef struct packed {
        ucs_state_e  state;
        logic [7:0]  mute_hi;
        logic [7:0]  mute_lo;
        logic [7:0]  io_slew;
        logic [7:0]  clk_slew;
        logic [7:0]  ctrl;
        logic [31:0] capture;
        logic [5:0]  bit_cnt;
        logic        src_s1;
        logic        src_s2;
        logic        src_prev;
        logic        io_s1;
        logic        io_s2;
        logic        card_clk;
        logic        card_rst;
        logic        aux1_oe_n;
        logic        aux2_oe_n;
        logic        active;
        logic [7:0]  rdata;
    } ucs_state_s;

endpackage : ucs_pkg

// ===== ucs_sync_ctrl.sv
`timescale 1ns/10ps
module ucs_sync_ctrl
    import ucs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    input  wire logic [1:0]  clk_static_sel_i,
    input  wire logic        async_mode_i,
    input  wire logic        auto_deact_i,
    input  wire logic        card_source_clock_i,
    input  wire logic        user_card_io_line_i,
    output logic      [7:0]  reg_rdata_o,
    output logic      [15:0] mute_timeout_o,
    output logic      [2:0]  io_rise_setting_o,
    output logic      [1:0]  io_fall_setting_o,
    output logic      [3:0]  card_clock_slew_o,
    output logic             user_card_clock_out_o,
    output logic             user_card_reset_out_o,
    output logic             aux1_out_o,
    output logic             aux1_oe_n_o,
    output logic             aux2_out_o,
    output logic             aux2_oe_n_o,
    output logic             interface_active_o
);

    ucs_state_s q;
    ucs_state_s d;

    logic src_rise;
    logic src_fall;
    logic sample_now;
    logic static_level;
    logic start_write;
    logic start_wdata;

    always_comb
    begin
        d = q;
        // only the stages after the first feed logic; the first stage may be metastable
        d.src_s1   = card_source_clock_i;
        d.src_s2   = q.src_s1;
        d.src_prev = q.src_s2;
        d.io_s1    = user_card_io_line_i;
        d.io_s2    = q.io_s1;

        src_rise    = q.src_s2 & ~q.src_prev;
        src_fall    = ~q.src_s2 & q.src_prev;
        sample_now  = q.ctrl[CTRL_EDGE] ? src_rise : src_fall;
        start_write = reg_wr_i && (reg_addr_i == ADDR_SYNC_CTRL);
        start_wdata = reg_wdata_i[CTRL_START];

        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                ADDR_MUTE_HI:   d.mute_hi  = reg_wdata_i;
                ADDR_MUTE_LO:   d.mute_lo  = reg_wdata_i;
                ADDR_IO_SLEW:   d.io_slew  = reg_wdata_i;
                ADDR_CLK_SLEW:  d.clk_slew = reg_wdata_i;
                ADDR_SYNC_CTRL: d.ctrl     = reg_wdata_i;
                default:        d.ctrl     = q.ctrl;
            endcase
        end

        // the card clock static level, low request taking precedence
        static_level = clk_static_sel_i[STATIC_LOW_BIT] ? 1'b0
                     : clk_static_sel_i[STATIC_HIGH_BIT];

        unique case (q.state)
            ST_IDLE:
            begin
                d.active   = 1'b0;
                d.card_clk = 1'b0;
                d.card_rst = 1'b0;
                d.bit_cnt  = CNT_ZERO;
                // a start while asynchronous operation owns the slot is ignored
                if (start_write && start_wdata && !async_mode_i)
                begin
                    d.active = 1'b1;
                    if (!reg_wdata_i[CTRL_ACT_MANUAL] && !reg_wdata_i[CTRL_CARD_TYPE])
                    begin
                        d.state    = ST_ANSWER;
                        d.card_rst = 1'b1;
                        d.capture  = RST_CAPTURE;
                    end
                    else
                    begin
                        d.state = ST_RUN;
                    end
                end
            end
            ST_ANSWER:
            begin
                // card clock starts low and only follows real source edges, so the
                // card never sees a runt rise on entry and shifts no bit unsampled
                if (src_rise)
                begin
                    d.card_clk = 1'b1;
                end
                else if (src_fall)
                begin
                    d.card_clk = 1'b0;
                end
                if (sample_now)
                begin
                    d.capture[q.bit_cnt[4:0]] = q.io_s2;
                    d.bit_cnt = q.bit_cnt + CNT_ONE;
                    if (q.bit_cnt == CNT_LAST)
                    begin
                        d.state    = ST_RUN;
                        d.card_rst = 1'b0;
                        d.ctrl[CTRL_RST_LEVEL] = 1'b0;
                    end
                end
            end
            ST_RUN:
            begin
                d.card_rst = q.ctrl[CTRL_RST_LEVEL];
                d.card_clk = q.ctrl[CTRL_CLK_GATE] ? q.src_s2 : static_level;
            end
            default:
            begin
                d.state = ST_IDLE;
            end
        endcase

        // clearing start or an automatic shutdown both end the session
        if (q.state != ST_IDLE)
        begin
            if ((start_write && !start_wdata) || auto_deact_i)
            begin
                d.state    = ST_IDLE;
                d.active   = 1'b0;
                d.card_clk = 1'b0;
                d.card_rst = 1'b0;
            end
            if (auto_deact_i)
            begin
                d.ctrl[CTRL_START] = 1'b0;
            end
        end

        // aux contacts are open drain: only a low is ever driven
        d.aux1_oe_n = ~(d.active & ~d.ctrl[CTRL_AUX1]);
        d.aux2_oe_n = ~(d.active & ~d.ctrl[CTRL_AUX2]);

        d.rdata = q.rdata;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ADDR_MUTE_HI:   d.rdata = q.mute_hi;
                ADDR_MUTE_LO:   d.rdata = q.mute_lo;
                ADDR_IO_SLEW:   d.rdata = {q.io_slew[IO_RISE_MSB:IO_FALL_LSB], 3'b000};
                ADDR_CLK_SLEW:  d.rdata = {q.clk_slew[CLK_SLEW_MSB:CLK_SLEW_LSB], 4'h0};
                ADDR_SYNC_CTRL: d.rdata = q.ctrl;
                ADDR_CAPTURE0:  d.rdata = q.capture[7:0];
                ADDR_CAPTURE1:  d.rdata = q.capture[15:8];
                ADDR_CAPTURE2:  d.rdata = q.capture[23:16];
                ADDR_CAPTURE3:  d.rdata = q.capture[31:24];
                default:        d.rdata = RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            q           <= '0;
            q.state     <= ST_IDLE;
            q.mute_hi   <= RST_MUTE_HI;
            q.mute_lo   <= RST_MUTE_LO;
            q.io_slew   <= RST_IO_SLEW;
            q.clk_slew  <= RST_CLK_SLEW;
            q.ctrl      <= RST_SYNC_CTRL;
            q.capture   <= RST_CAPTURE;
            q.aux1_oe_n <= 1'b1;
            q.aux2_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata_o           = q.rdata;
    assign mute_timeout_o        = {q.mute_hi, q.mute_lo};
    assign io_rise_setting_o     = q.io_slew[IO_RISE_MSB:IO_RISE_LSB];
    assign io_fall_setting_o     = q.io_slew[IO_FALL_MSB:IO_FALL_LSB];
    assign card_clock_slew_o     = q.clk_slew[CLK_SLEW_MSB:CLK_SLEW_LSB];
    assign user_card_clock_out_o = q.card_clk;
    assign user_card_reset_out_o = q.card_rst;
    assign aux1_out_o            = 1'b0;
    assign aux1_oe_n_o           = q.aux1_oe_n;
    assign aux2_out_o            = 1'b0;
    assign aux2_oe_n_o           = q.aux2_oe_n;
    assign interface_active_o    = q.active;

endmodule : ucs_sync_ctrl

// ===== ucs_sync_ctrl_assertions.sv
`timescale 1ns/10ps
module ucs_sync_ctrl_assertions
    import ucs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic        async_mode_i,
    input wire logic        auto_deact_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic [15:0] mute_timeout_o,
    input wire logic [2:0]  io_rise_setting_o,
    input wire logic [3:0]  card_clock_slew_o,
    input wire logic        user_card_reset_out_o,
    input wire logic        aux1_oe_n_o,
    input wire logic        interface_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // a start write only counts while idle and with no fault clear in the same cycle
    wire logic start_wr = reg_wr_i && reg_addr_i == ADDR_SYNC_CTRL && reg_wdata_i[0]
        && !interface_active_o && !auto_deact_i;
    unmap_rd_a: assert property (reg_rd_i && reg_addr_i > ADDR_CAPTURE3 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    mute_low_a: assert property (reg_wr_i && reg_addr_i == ADDR_MUTE_LO |=> mute_timeout_o[7:0] == $past(reg_wdata_i))
        else $error("mute low byte not written");
    mute_high_a: assert property (reg_wr_i && reg_addr_i == ADDR_MUTE_HI |=> mute_timeout_o[15:8] == $past(reg_wdata_i))
        else $error("mute high byte not written");
    io_rise_a: assert property (reg_wr_i && reg_addr_i == ADDR_IO_SLEW |=> io_rise_setting_o == $past(reg_wdata_i[7:5]))
        else $error("io rise field not written");
    clk_slew_a: assert property (reg_wr_i && reg_addr_i == ADDR_CLK_SLEW |=> card_clock_slew_o == $past(reg_wdata_i[7:4]))
        else $error("clock slew field not written");
    start_act_a: assert property (start_wr && !async_mode_i |=> interface_active_o)
        else $error("start did not activate");
    async_ign_a: assert property (start_wr && async_mode_i |=> !interface_active_o)
        else $error("start taken in async mode");
    fault_stop_a: assert property (auto_deact_i |=> !interface_active_o && !user_card_reset_out_o)
        else $error("fault did not deactivate");
    idle_aux_a: assert property (!interface_active_o && !$past(interface_active_o) |-> aux1_oe_n_o)
        else $error("aux driven while idle");
    cover property ($fell(user_card_reset_out_o) && interface_active_o);
    cover property (interface_active_o && !aux1_oe_n_o);
    cover property (auto_deact_i && interface_active_o);
endmodule : ucs_sync_ctrl_assertions

bind ucs_sync_ctrl ucs_sync_ctrl_assertions chk (.*);

// ===== ucs_card_model.sv
`timescale 1ns/10ps
module ucs_card_model #(
    parameter logic [31:0] ANSWER = 32'hC3A5_5A0F
) (
    input  wire logic card_clk_i,
    input  wire logic card_rst_i,
    output logic      io_o
);
    int idx = 0;
    // released line sits at the pull-up level
    initial io_o = 1'b1;
    always @(posedge card_rst_i)
    begin
        idx = 0;
        io_o = ANSWER[0];
    end
    // next bit after each falling card clock edge, steady at the rising one
    always @(negedge card_clk_i) if (card_rst_i && idx < 31) io_o = ANSWER[++idx];
    always @(negedge card_rst_i) io_o = 1'b1;
endmodule : ucs_card_model

// ===== ucs_sync_ctrl_tb.sv
`timescale 1ns/10ps
module ucs_sync_ctrl_tb
    import ucs_pkg::*;
;
    logic        clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, async_mode_i = 0;
    logic        auto_deact_i = 0, card_source_clock_i = 0, user_card_io_line_i;
    logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, got;
    logic [1:0]  clk_static_sel_i = 0, io_fall_setting_o;
    logic [15:0] mute_timeout_o;
    logic [2:0]  io_rise_setting_o;
    logic [3:0]  card_clock_slew_o;
    logic        user_card_clock_out_o, user_card_reset_out_o, interface_active_o;
    logic        aux1_out_o, aux1_oe_n_o, aux2_out_o, aux2_oe_n_o;
    int          err_total = 0, checks = 0, cyc = 0;
    localparam logic [31:0] ANS = 32'hC3A5_5A0F;
    localparam logic [7:0]  RST_TAB [10] = '{8'hA4, 8'h74, 8'h80, 8'hA0, 8'h76, 0, 0, 0, 0, 0};
    ucs_sync_ctrl dut (.*);
    ucs_card_model #(.ANSWER(ANS)) card (.card_clk_i(user_card_clock_out_o),
        .card_rst_i(user_card_reset_out_o), .io_o(user_card_io_line_i));
    initial forever #50 clk_i = ~clk_i;
    initial forever #800 card_source_clock_i = ~card_source_clock_i;
    always @(posedge clk_i) if (cyc++ == 20000) wrap_up(1'b1);
    task wrap_up(input bit hang);
        if (hang) err_total++;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(negedge clk_i);
        {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        @(negedge clk_i);
        got = reg_rdata_o;
    endtask : rd
    task t_reset;
        for (int i = 0; i < 10; i++)
        begin
            rd(8'h05 + 8'(i));
            chk(got, RST_TAB[i]);
        end
        chk({interface_active_o, user_card_reset_out_o, aux1_oe_n_o}, 3'b001);
        $display("reset values done");
    endtask : t_reset
    task t_rw;
        wr(8'h05, 8'h5A);
        wr(8'h06, 8'hC3);
        wr(8'h07, 8'hFF);
        wr(8'h08, 8'hFF);
        wr(8'h0A, 8'hFF);
        chk(mute_timeout_o, 16'h5AC3);
        chk({io_rise_setting_o, io_fall_setting_o, card_clock_slew_o}, 9'h1FF);
        rd(8'h07);
        chk(got, 8'hF8);
        rd(8'h0A);
        chk(got, 8'h00);
        $display("read write done");
    endtask : t_rw
    task t_type1;
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h09, (e != 0) ? 8'h37 : 8'h35);
            repeat (3) @(negedge clk_i);
            chk({interface_active_o, user_card_reset_out_o}, 2'b11);
            for (int n = 0; n < 2000 && user_card_reset_out_o === 1'b1; n++) @(negedge clk_i);
            chk(user_card_reset_out_o, 1'b0);
            for (int i = 0; i < 4; i++)
            begin
                rd(8'h0A + 8'(i));
                chk(got, ANS[8*i +: 8]);
            end
            wr(8'h09, 8'h36);
            chk(interface_active_o, 1'b0);
        end
        $display("type 1 done");
    endtask : t_type1
    task t_manual;
        clk_static_sel_i = 2'b01;
        wr(8'h09, 8'h59);
        repeat (4) @(negedge clk_i);
        chk({interface_active_o, user_card_reset_out_o, aux1_oe_n_o, aux2_oe_n_o,
             user_card_clock_out_o}, 5'b11011);
        chk({aux1_out_o, aux2_out_o}, 2'b00);
        clk_static_sel_i = 2'b11;
        repeat (4) @(negedge clk_i);
        chk(user_card_clock_out_o, 1'b0);
        auto_deact_i = 1'b1;
        @(negedge clk_i);
        auto_deact_i = 1'b0;
        rd(8'h09);
        chk({interface_active_o, got}, 9'h058);
        $display("manual done");
    endtask : t_manual
    task t_type2;
        async_mode_i = 1'b1;
        wr(8'hB9 ^ 8'h00, 8'hB9);
        wr(8'h09, 8'hB9);
        repeat (3) @(negedge clk_i);
        chk(interface_active_o, 1'b0);
        async_mode_i = 1'b0;
        wr(8'h09, 8'hB8);
        wr(8'h09, 8'hB9);
        repeat (3) @(negedge clk_i);
        chk({interface_active_o, user_card_reset_out_o}, 2'b11);
        $display("type 2 done");
    endtask : t_type2
    initial
    begin
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_rw();
        t_type1();
        t_manual();
        t_type2();
        wrap_up(1'b0);
    end
endmodule : ucs_sync_ctrl_tb
